// file: pss_pkg.sv
// pss_pkg: constants, types and register map of the power-up setpoint sequencer
// assumes: pclk at 50 MHz, apb slave with 32-bit data, one word per register
package pss_pkg;
    // clock rate and derived timing
    localparam int unsigned CLK_HZ = 50000000;
    localparam int unsigned CHECK_MS = 5; // memory check, least figure
    localparam int unsigned MIN_DELAY_MS = 2; // least pre-ramp delay
    localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
    localparam int unsigned CHECK_CYC = CHECK_MS * CYC_PER_MS;
    localparam int unsigned MIN_DELAY_CYC = MIN_DELAY_MS * CYC_PER_MS;
    // setpoints in millivolts
    localparam logic [15:0] MV_MIN = 16'h0258; // 0.6 V
    localparam logic [15:0] MV_MAX = 16'h1388; // 5.0 V
    localparam logic [15:0] MV_STRAP_LO = 16'h04b0; // 1.2 V
    localparam logic [15:0] MV_STRAP_OPEN = 16'h05dc; // 1.5 V
    localparam logic [15:0] MV_STRAP_HI = 16'h0ce4; // 3.3 V
    // register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_VOUT = 8'h08;
    localparam logic [7:0] OFS_DELAY = 8'h0c;
    localparam logic [7:0] OFS_RAMP = 8'h10;
    localparam logic [7:0] OFS_CEIL = 8'h14;
    localparam logic [7:0] OFS_NVM = 8'h18;
    // ctrl field positions
    localparam int unsigned CTRL_RESTORE_BIT = 0;
    localparam int unsigned CTRL_SAVE_BIT = 1;
    // reset values
    localparam logic [15:0] RST_DELAY_MS = 16'h0000;
    localparam logic [15:0] RST_RAMP_MS = 16'h0005;
    // strap states of a multi-mode pin
    typedef enum logic [1:0] {
        PSS_PIN_LOW = 2'h0,
        PSS_PIN_OPEN = 2'h1,
        PSS_PIN_HIGH = 2'h2,
        PSS_PIN_RES = 2'h3
    } pss_pin_e;
    // one multi-mode pin: strap state and resistor index
    typedef struct packed {
        pss_pin_e mode;
        logic [4:0] res_idx;
    } pss_pin_s;
    // saved configuration image
    typedef struct packed {
        logic valid;
        logic [15:0] vout_mv;
        logic [15:0] delay_ms;
        logic [15:0] ramp_ms;
    } pss_cfg_s;
    // sequencer states, one-hot
    typedef enum logic [5:0] {
        PSS_CHECK = 6'h01,
        PSS_PINS = 6'h02,
        PSS_READY = 6'h04,
        PSS_DELAY = 6'h08,
        PSS_RAMP = 6'h10,
        PSS_ON = 6'h20
    } pss_state_e;
endpackage : pss_pkg

// file: pss_msync.sv
// pss_msync: three-stage synchroniser with agreement filter for a W-bit group of pins
// assumes: input arrives asynchronously to pclk
`timescale 1ns/1ps
`default_nettype none
module pss_msync #(
    parameter int unsigned W = 1
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    logic [W-1:0] s1_ff, s2_ff, s3_ff; // synchroniser chain
    logic [W-1:0] nxt_dout;
    // take new value only when stages two and three agree
    always_comb begin
        nxt_dout = dout;
        if (s2_ff == s3_ff) begin
            nxt_dout = s3_ff;
        end
    end
    // chain and filtered output
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_ff <= '0;
            s2_ff <= '0;
            s3_ff <= '0;
            dout <= '0;
        end else begin
            s1_ff <= din;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            dout <= nxt_dout;
        end
    end
endmodule : pss_msync
`default_nettype wire

// file: pss_restab.sv
// pss_restab: resistor index to millivolt table, registered read
// assumes: index 0..30 follows the standard e96 step list
`timescale 1ns/1ps
`default_nettype none
module pss_restab (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [4:0] idx,
    output logic [15:0] mv
);
    logic [15:0] nxt_mv;
    // table lookup: 10k is 0.6 V up to 162k 3.3 V, 178k 5.0 V
    always_comb begin
        case (idx)
            5'h00: nxt_mv = 16'd600;
            5'h01: nxt_mv = 16'd700;
            5'h02: nxt_mv = 16'd750;
            5'h03: nxt_mv = 16'd800;
            5'h04: nxt_mv = 16'd900;
            5'h05: nxt_mv = 16'd1000;
            5'h06: nxt_mv = 16'd1100;
            5'h07: nxt_mv = 16'd1200;
            5'h08: nxt_mv = 16'd1250;
            5'h09: nxt_mv = 16'd1300;
            5'h0a: nxt_mv = 16'd1400;
            5'h0b: nxt_mv = 16'd1500;
            5'h0c: nxt_mv = 16'd1600;
            5'h0d: nxt_mv = 16'd1700;
            5'h0e: nxt_mv = 16'd1800;
            5'h0f: nxt_mv = 16'd1900;
            5'h10: nxt_mv = 16'd2000;
            5'h11: nxt_mv = 16'd2100;
            5'h12: nxt_mv = 16'd2200;
            5'h13: nxt_mv = 16'd2300;
            5'h14: nxt_mv = 16'd2400;
            5'h15: nxt_mv = 16'd2500;
            5'h16: nxt_mv = 16'd2600;
            5'h17: nxt_mv = 16'd2700;
            5'h18: nxt_mv = 16'd2800;
            5'h19: nxt_mv = 16'd2900;
            5'h1a: nxt_mv = 16'd3000;
            5'h1b: nxt_mv = 16'd3100;
            5'h1c: nxt_mv = 16'd3200;
            5'h1d: nxt_mv = 16'd3300;
            default: nxt_mv = 16'd5000; // 178k and above
        endcase
    end
    // registered read
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mv <= 16'h0000;
        end else begin
            mv <= nxt_mv;
        end
    end
endmodule : pss_restab

// file: pss_seq.sv
// pss_seq: start-up sequencer, setpoint selection and apb register file
// assumes: apb master on pclk; strap pins and enable are asynchronous
//
// Decided for this implementation: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module pss_seq #(
    parameter int unsigned CHECK_CYC = pss_pkg::CHECK_CYC,
    parameter int unsigned MIN_DELAY_CYC = pss_pkg::MIN_DELAY_CYC,
    parameter int unsigned CYC_PER_MS = pss_pkg::CYC_PER_MS
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic enable_in,
    input wire logic [6:0] output_setpoint_pin,
    input wire pss_pkg::pss_cfg_s nvm_cfg,
    output logic device_ready,
    output logic ramp_active,
    output logic output_on,
    output logic [15:0] target_mv,
    output logic [15:0] output_ceiling_limit
);
    // synchronised pins: mode in [6:5], resistor index in [4:0], enable
    logic [7:0] pins_sync;
    pss_msync #(.W(8)) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .din({enable_in, output_setpoint_pin}),
        .dout(pins_sync)
    );
    pss_pkg::pss_pin_s pin_now; // live pin view
    logic en_sync; // filtered enable
    assign pin_now = pss_pkg::pss_pin_s'(pins_sync[6:0]);
    assign en_sync = pins_sync[7];
    // resistor table lookup
    logic [15:0] res_mv;
    pss_restab u_tab (
        .pclk(pclk),
        .presetn(presetn),
        .idx(pin_now.res_idx),
        .mv(res_mv)
    );

    // state
    pss_pkg::pss_state_e state_ff, nxt_state;
    logic [31:0] cnt_ff, nxt_cnt; // phase timer
    logic [15:0] vout_ff, nxt_vout; // active setpoint
    logic [15:0] ceil_ff, nxt_ceil; // latched ceiling
    logic [15:0] delay_ff, nxt_delay; // configured delay ms
    logic [15:0] ramp_ff, nxt_ramp; // configured ramp ms
    logic [15:0] strap_ff, nxt_strap; // pin-selected setpoint
    logic restore_ff, nxt_restore; // restore request pending
    logic save_ff, nxt_save; // save request flag
    logic [31:0] delay_cyc; // effective delay
    logic [31:0] ramp_cyc; // ramp length
    logic [15:0] strap_mv; // decoded strap value
    logic wr_acc, rd_acc; // apb access phase strobes
    logic addr_ok; // decoded address

    // four-way decode of the setpoint strap: low, open, high, or resistor table value
    always_comb begin
        case (pin_now.mode)
            pss_pkg::PSS_PIN_LOW: strap_mv = pss_pkg::MV_STRAP_LO;
            pss_pkg::PSS_PIN_OPEN: strap_mv = pss_pkg::MV_STRAP_OPEN;
            pss_pkg::PSS_PIN_HIGH: strap_mv = pss_pkg::MV_STRAP_HI;
            default: strap_mv = res_mv;
        endcase
    end

    // delay is the longer of 2 ms and the configured one
    always_comb begin
        delay_cyc = 32'(delay_ff) * 32'(CYC_PER_MS);
        if (delay_cyc < 32'(MIN_DELAY_CYC)) begin
            delay_cyc = 32'(MIN_DELAY_CYC);
        end // longer values kept as is
        ramp_cyc = 32'(ramp_ff) * 32'(CYC_PER_MS);
    end

    // bus strobes, writes only accepted once ready
    // write lands only at the pready edge, and never when the answer is an error
    assign wr_acc = psel && penable && pwrite && pready && !pslverr;
    assign rd_acc = psel && penable && !pwrite;
    always_comb begin
        if (paddr == pss_pkg::OFS_CTRL) begin
            addr_ok = 1'b1;
        end else if (paddr == pss_pkg::OFS_STATUS) begin
            addr_ok = 1'b1;
        end else if (paddr == pss_pkg::OFS_VOUT) begin
            addr_ok = 1'b1;
        end else if (paddr == pss_pkg::OFS_DELAY) begin
            addr_ok = 1'b1;
        end else if (paddr == pss_pkg::OFS_RAMP) begin
            addr_ok = 1'b1;
        end else if (paddr == pss_pkg::OFS_CEIL) begin
            addr_ok = 1'b1;
        end else if (paddr == pss_pkg::OFS_NVM) begin
            addr_ok = 1'b1;
        end else begin
            addr_ok = 1'b0;
        end
    end

    // sequencer and configuration next state
    always_comb begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff + 32'h1;
        nxt_vout = vout_ff;
        nxt_ceil = ceil_ff;
        nxt_delay = delay_ff;
        nxt_ramp = ramp_ff;
        nxt_strap = strap_ff;
        nxt_restore = restore_ff;
        nxt_save = save_ff;
        // register writes while ready
        if (wr_acc) begin
            if (paddr == pss_pkg::OFS_CTRL) begin
                nxt_restore = pwdata[pss_pkg::CTRL_RESTORE_BIT];
                nxt_save = pwdata[pss_pkg::CTRL_SAVE_BIT];
            end else if (paddr == pss_pkg::OFS_VOUT) begin
                // writes outside 0.6..5.0 V ignored
                if (pwdata[15:0] >= pss_pkg::MV_MIN && pwdata[15:0] <= pss_pkg::MV_MAX) begin
                    nxt_vout = pwdata[15:0];
                end
            end else if (paddr == pss_pkg::OFS_DELAY) begin
                nxt_delay = pwdata[15:0];
            end else if (paddr == pss_pkg::OFS_RAMP) begin
                nxt_ramp = pwdata[15:0];
            end
        end
        case (state_ff)
            pss_pkg::PSS_CHECK: begin
                // enable and bus writes ignored here
                if (cnt_ff >= 32'(CHECK_CYC) - 32'h1) begin
                    nxt_state = pss_pkg::PSS_PINS;
                    nxt_cnt = 32'h0;
                    if (nvm_cfg.valid) begin
                        nxt_vout = nvm_cfg.vout_mv;
                        nxt_delay = nvm_cfg.delay_ms;
                        nxt_ramp = nvm_cfg.ramp_ms;
                    end
                end
            end
            pss_pkg::PSS_PINS: begin
                // wait one cycle for the table read, then sample
                if (cnt_ff == 32'h1) begin
                    nxt_strap = strap_mv;
                    nxt_ceil = 16'((32'(strap_mv) * 32'd11) / 32'd10);
                    if (!nvm_cfg.valid) begin
                        nxt_vout = strap_mv;
                    end
                    nxt_state = pss_pkg::PSS_READY;
                    nxt_cnt = 32'h0;
                end
            end
            pss_pkg::PSS_READY: begin
                nxt_cnt = 32'h0;
                if (en_sync) begin
                    nxt_state = pss_pkg::PSS_DELAY;
                end
            end
            pss_pkg::PSS_DELAY: begin
                if (!en_sync) begin
                    nxt_state = pss_pkg::PSS_READY;
                end else if (cnt_ff >= delay_cyc - 32'h1) begin
                    nxt_state = pss_pkg::PSS_RAMP;
                    nxt_cnt = 32'h0;
                end
            end
            pss_pkg::PSS_RAMP: begin
                if (!en_sync) begin
                    nxt_state = pss_pkg::PSS_READY;
                end else if (cnt_ff + 32'h1 >= ramp_cyc) begin
                    nxt_state = pss_pkg::PSS_ON;
                end
            end
            pss_pkg::PSS_ON: begin
                nxt_cnt = 32'h0;
                if (!en_sync) begin
                    nxt_state = pss_pkg::PSS_READY;
                end
            end
            default: begin
                nxt_state = pss_pkg::PSS_CHECK;
                nxt_cnt = 32'h0;
            end
        endcase
        // restore reruns the whole start-up
        if (restore_ff) begin
            nxt_state = pss_pkg::PSS_CHECK;
            nxt_cnt = 32'h0;
            nxt_restore = 1'b0;
        end
    end

    // state registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff <= pss_pkg::PSS_CHECK;
            cnt_ff <= 32'h0;
            vout_ff <= pss_pkg::MV_MIN;
            ceil_ff <= pss_pkg::MV_MIN;
            delay_ff <= pss_pkg::RST_DELAY_MS;
            ramp_ff <= pss_pkg::RST_RAMP_MS;
            strap_ff <= pss_pkg::MV_MIN;
            restore_ff <= 1'b0;
            save_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            vout_ff <= nxt_vout;
            ceil_ff <= nxt_ceil;
            delay_ff <= nxt_delay;
            ramp_ff <= nxt_ramp;
            strap_ff <= nxt_strap;
            restore_ff <= nxt_restore;
            save_ff <= nxt_save;
        end
    end

    // read mux and registered outputs
    logic [31:0] nxt_rdata;
    always_comb begin
        nxt_rdata = 32'h0;
        if (paddr == pss_pkg::OFS_STATUS) begin
            nxt_rdata = {26'h0, state_ff};
        end else if (paddr == pss_pkg::OFS_VOUT) begin
            nxt_rdata = {16'h0, vout_ff};
        end else if (paddr == pss_pkg::OFS_DELAY) begin
            nxt_rdata = {16'h0, delay_ff};
        end else if (paddr == pss_pkg::OFS_RAMP) begin
            nxt_rdata = {16'h0, ramp_ff};
        end else if (paddr == pss_pkg::OFS_CEIL) begin
            nxt_rdata = {16'h0, ceil_ff};
        end else if (paddr == pss_pkg::OFS_NVM) begin
            nxt_rdata = {15'h0, save_ff, strap_ff};
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
            pready <= 1'b0;
            pslverr <= 1'b0;
            device_ready <= 1'b0;
            ramp_active <= 1'b0;
            output_on <= 1'b0;
            target_mv <= 16'h0;
            output_ceiling_limit <= 16'h0;
        end else begin
            // one wait state: answer in the cycle after access starts
            pready <= psel && penable && !pready;
            pslverr <= psel && penable && !pready && (!addr_ok || (pwrite && !device_ready));
            prdata <= (rd_acc && !pready) ? nxt_rdata : 32'h0;
            device_ready <= (nxt_state != pss_pkg::PSS_CHECK) && (nxt_state != pss_pkg::PSS_PINS);
            ramp_active <= nxt_state == pss_pkg::PSS_RAMP;
            output_on <= nxt_state == pss_pkg::PSS_ON;
            target_mv <= nxt_vout;
            output_ceiling_limit <= nxt_ceil;
        end
    end

    // helper: cycles spent in delay before ramp
    logic [31:0] dly_seen_ff;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dly_seen_ff <= 32'h0;
        end else if (state_ff == pss_pkg::PSS_DELAY) begin
            dly_seen_ff <= dly_seen_ff + 32'h1;
        end else begin
            dly_seen_ff <= 32'h0;
        end
    end

    AST_CHECK_IGNORES_EN: assert property (@(posedge pclk) disable iff (!presetn)
        (state_ff == pss_pkg::PSS_CHECK) && !restore_ff |=> state_ff != pss_pkg::PSS_DELAY)
        else $error("enable acted during memory check");
    AST_NO_WRITE_BEFORE_READY: assert property (@(posedge pclk) disable iff (!presetn)
        psel && penable && pwrite && !device_ready && (paddr == pss_pkg::OFS_DELAY) |=> $stable(delay_ff))
        else $error("write taken before ready");
    AST_RESTORE_RECHECK: assert property (@(posedge pclk) disable iff (!presetn)
        restore_ff |=> state_ff == pss_pkg::PSS_CHECK && cnt_ff == 32'h0)
        else $error("restore did not restart check");
    AST_MIN_DELAY: assert property (@(posedge pclk) disable iff (!presetn)
        (state_ff == pss_pkg::PSS_DELAY) && (nxt_state == pss_pkg::PSS_RAMP) |-> dly_seen_ff + 32'h1 >= 32'(MIN_DELAY_CYC))
        else $error("ramp began before least delay");
    AST_FULL_DELAY: assert property (@(posedge pclk) disable iff (!presetn)
        (state_ff == pss_pkg::PSS_DELAY) && (nxt_state == pss_pkg::PSS_RAMP) |-> dly_seen_ff + 32'h1 >= delay_cyc)
        else $error("ramp began before configured delay");
    AST_STRAP_DECODE: assert property (@(posedge pclk) disable iff (!presetn)
        (pin_now.mode == pss_pkg::PSS_PIN_HIGH) |-> strap_mv == 16'd3300)
        else $error("high strap not 3.3 V");
    AST_CEILING: assert property (@(posedge pclk) disable iff (!presetn)
        state_ff == pss_pkg::PSS_PINS && nxt_state == pss_pkg::PSS_READY |=> ceil_ff == 16'((32'(strap_ff) * 32'd11) / 32'd10))
        else $error("ceiling not setpoint plus ten percent");
    AST_PINS_FROZEN: assert property (@(posedge pclk) disable iff (!presetn)
        state_ff == pss_pkg::PSS_READY && !restore_ff |=> $stable(strap_ff))
        else $error("pin setpoint changed after sampling");
    AST_VOUT_RANGE: assert property (@(posedge pclk) disable iff (!presetn)
        wr_acc && paddr == pss_pkg::OFS_VOUT && pwdata[15:0] == pss_pkg::MV_MAX |=> vout_ff == pss_pkg::MV_MAX)
        else $error("5.0 V setpoint write refused");
endmodule : pss_seq
`default_nettype wire

// file: pss_far.sv
// pss_far: far-end model driving the enable pin and the strap pins
// assumes: requests come from the bench on pclk edges
`timescale 1ns/1ps
`default_nettype none
module pss_far (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic en_req,
    input wire logic [6:0] pin_req,
    output logic enable_in,
    output logic [6:0] pins
);
    logic [2:0] settle_ff; // external clock settling count
    // external clock settles a few cycles after reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            settle_ff <= 3'h0;
        end else if (settle_ff != 3'h7) begin
            settle_ff <= settle_ff + 3'h1;
        end
    end
    // enable only once the clock is stable
    assign enable_in = en_req && (settle_ff == 3'h7);
    assign pins = pin_req; // strap level as wired
endmodule : pss_far
`default_nettype wire

// file: tb_top.sv
// tb_top: self-checking bench for the setpoint sequencer
// assumes: shortened counts, apb driven on rising edges
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    localparam int CHK = 20; // memory check cycles
    localparam int MIND = 8; // least delay cycles
    localparam int CPM = 4; // cycles per ms
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, en_req;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [6:0] pin_req, pins;
    logic enable_in, device_ready, ramp_active, output_on;
    logic [15:0] target_mv, ceil;
    pss_pkg::pss_cfg_s nvm;
    int n_errors, comparisons, cyc, rel, n;
    logic [6:0] tp [6] = '{7'h00, 7'h20, 7'h40, 7'h60, 7'h7d, 7'h7f}; // strap codes
    logic [15:0] tv [6] = '{16'h04b0, 16'h05dc, 16'h0ce4, 16'h0258, 16'h0ce4, 16'h1388};
    logic [31:0] wv [4] = '{32'h0258, 32'h1388, 32'h0257, 32'h1389};
    logic [31:0] xv [4] = '{32'h0258, 32'h1388, 32'h1388, 32'h1388};
    pss_seq #(.CHECK_CYC(CHK), .MIN_DELAY_CYC(MIND), .CYC_PER_MS(CPM)) i_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .enable_in(enable_in), .output_setpoint_pin(pins), .nvm_cfg(nvm),
        .device_ready(device_ready), .ramp_active(ramp_active), .output_on(output_on),
        .target_mv(target_mv), .output_ceiling_limit(ceil)
    );
    pss_far i_far (.pclk(pclk), .presetn(presetn), .en_req(en_req), .pin_req(pin_req),
        .enable_in(enable_in), .pins(pins));
    // clock and cycle count with hang limit
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cyc++;
        if (cyc >= 20000) begin
            n_errors++;
            give_verdict();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic chk_rng(input int got, input int lo, input int hi);
        comparisons++;
        if (got < lo || got > hi) begin
            n_errors++;
            $display("unexpected at %0t: count %h not in %h..%h", $time, got, lo, hi);
        end
    endtask : chk_rng
    // one apb transfer, result in rd and err
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        rd = prdata;
        err = pslverr;
        if (k >= 50) n_errors++;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // wait for a condition, count cycles
    task automatic wait_on(input int which);
        logic s;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
            case (which)
                0: s = device_ready;
                1: s = ramp_active;
                2: s = output_on;
                default: s = ~device_ready;
            endcase
        end while (s !== 1'b1 && n < 300);
    endtask : wait_on
    // enable, measure delay and ramp, disable
    task automatic ramp_run(input int d_ms, input int r_ms);
        apb(1'b1, pss_pkg::OFS_DELAY, d_ms);
        apb(1'b1, pss_pkg::OFS_RAMP, r_ms);
        en_req <= 1'b1;
        wait_on(1);
        chk_rng(n, (d_ms * CPM > MIND) ? d_ms * CPM : MIND, ((d_ms * CPM > MIND) ? d_ms * CPM : MIND) + 8);
        wait_on(2);
        chk_rng(n, (r_ms > 0) ? r_ms * CPM : 1, r_ms * CPM + 2);
        en_req <= 1'b0;
        repeat (10) @(posedge pclk);
        chk(output_on, 1'b0);
    endtask : ramp_run
    task automatic restore();
        apb(1'b1, pss_pkg::OFS_CTRL, 32'h1);
        wait_on(3);
        chk_rng(n, 0, 4);
        wait_on(0);
        chk_rng(n, CHK, CHK + 8);
    endtask : restore
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : give_verdict
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        n_errors = 0;
        comparisons = 0;
        cyc = 0;
        en_req = 1'b1; // enable driven high from power-up, dropped once the ramp starts
        pin_req = 7'h40;
        nvm = '0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        rel = cyc;
        apb(1'b1, pss_pkg::OFS_DELAY, 32'h7);
        chk(err, 1'b1);
        apb(1'b0, pss_pkg::OFS_RAMP, 0);
        chk(rd, 32'h5);
        wait_on(0);
        chk_rng(cyc - rel, CHK, CHK + 8);
        chk(ramp_active, 1'b0);
        chk(target_mv, 16'h0ce4);
        wait_on(1);
        chk_rng(n, MIND, MIND + 8);
        en_req <= 1'b0;
        repeat (8) @(posedge pclk); // let the cut ramp fall back to ready
        $display("test power-up done");
        apb(1'b0, pss_pkg::OFS_STATUS, 0);
        chk(rd, 32'h4);
        apb(1'b0, pss_pkg::OFS_CEIL, 0);
        chk(rd, 32'h0e2e);
        apb(1'b0, 8'h1c, 0);
        chk(err, 1'b1);
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, pss_pkg::OFS_VOUT, wv[i]);
            chk(err, 1'b0);
            apb(1'b0, pss_pkg::OFS_VOUT, 0);
            chk(rd, xv[i]);
        end
        $display("test registers done");
        ramp_run(0, 2);
        ramp_run(5, 0);
        $display("test ramp done");
        pin_req <= 7'h00;
        repeat (10) @(posedge pclk);
        chk(ceil, 16'h0e2e);
        for (int i = 0; i < 6; i++) begin
            pin_req <= tp[i];
            repeat (6) @(posedge pclk);
            restore();
            chk(target_mv, tv[i]);
            chk(ceil, tv[i] + tv[i] / 10);
        end
        nvm <= '{valid: 1'b1, vout_mv: 16'h07d0, delay_ms: 16'h0, ramp_ms: 16'h3};
        restore();
        chk(target_mv, 16'h07d0);
        chk(ceil, 16'h157c);
        apb(1'b0, pss_pkg::OFS_RAMP, 0);
        chk(rd, 32'h3);
        apb(1'b1, pss_pkg::OFS_CTRL, 32'h2);
        apb(1'b0, pss_pkg::OFS_NVM, 0);
        chk(rd, 32'h00011388);
        $display("test restore done");
        give_verdict();
    end
endmodule : tb_top
`default_nettype wire
